// File: core/rfr_cfg_status_regs.sv
// configuration and status register set of the reader front end
// assumes a register port decoded upstream and one-cycle event pulses from the framer
`timescale 1ns/1ns
`include "rfr_params.svh"

module rfr_cfg_status_regs (
    // clock and resets
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             enable_i,
    // register port
    input  wire rfr_pkg::rfr_addr_t reg_addr_i,
    input  wire logic             reg_wr_i,
    input  wire rfr_pkg::rfr_byte_t reg_wdata_i,
    input  wire logic             reg_rd_i,
    input  wire logic             read_phase_end_i,
    output rfr_pkg::rfr_byte_t    reg_rdata_o,
    // protocol select
    input  wire logic             proto_wr_i,
    input  wire logic [4:0]       proto_mode_i,
    input  wire logic             direct_mode_i,
    // framer events
    input  wire logic             tx_start_i,
    input  wire logic             tx_end_i,
    input  wire logic             rx_sof_i,
    input  wire logic             rx_end_i,
    input  wire logic             crc_err_i,
    input  wire logic             parity_err_i,
    input  wire logic             framing_err_i,
    input  wire logic             collision_i,
    input  wire logic             noresp_i,
    input  wire logic [9:0]       bit_pos_i,
    // fifo and analog status
    input  wire logic [3:0]       fifo_level_i,
    input  wire logic             fifo_overflow_i,
    input  wire logic [2:0]       active_strength_i,
    input  wire logic [2:0]       aux_strength_i,
    input  wire logic             osc_stable_i,
    // modulation and clock
    input  wire logic             carrier_i,
    input  wire logic             ask_ook_pin_i,
    output logic                  system_clock_output_o,
    output logic                  mod_ook_o,
    output logic [2:0]            mod_depth_o,
    output logic                  analog_test_en_o,
    // receive path
    output logic                  rx_ignore_o,
    output logic [3:0]            filter_sel_o,
    output logic [1:0]            gain_cut_o,
    output logic [7:0]            regulator_ctrl_o,
    // transmit length
    output logic [11:0]           tx_byte_count_o,
    output logic [3:0]            last_byte_bits_o,
    // interrupt
    output logic                  irq_o
);
    import rfr_pkg::*;

    localparam int unsigned STEP_CYC = `RFR_RXW_STEP_CYCLES;
    localparam logic [7:0] PRE_VIC  = 8'(`RFR_STEPS(`RFR_PRESET_VIC_US));
    localparam logic [7:0] PRE_PROX = 8'(`RFR_STEPS(`RFR_PRESET_PROX_US));
    localparam logic [7:0] PRE_PROP = 8'(`RFR_STEPS(`RFR_PRESET_PROP_US));

    logic       sreset;
    logic [7:0] rx_wait;
    logic [7:0] mod_ctrl;
    logic [7:0] filt_gain;
    logic [7:0] regulator;
    logic [7:0] cause;
    logic [5:0] irq_mask;
    logic [9:0] col_pos;
    logic [6:0] strength;
    logic [7:0] tx_upper;
    logic [7:0] tx_lower;
    logic       irq_req;
    logic [4:0] proto_mode;
    rfr_proto_e next_kind;
    logic [7:0] next_preset;
    logic       col_capable;
    logic       wr_hit_mod;
    logic [5:0] err_events;
    logic       fifo_cond;
    logic       fifo_cond_q;
    logic [7:0] fifo_state;
    logic [7:0] rdata;
    logic [11:0] step_cnt;
    logic [7:0] steps_left;
    logic       carrier_q;
    logic [1:0] div_cnt;

    assign sreset = rst_i | ~enable_i; // enable pin low acts like power-on reset

    // protocol family from the 5-bit mode code
    always_comb begin
        case (proto_mode_i[4:2])
            3'b000, 3'b001: next_kind = RFR_PROTO_VICINITY;
            3'b010, 3'b011: next_kind = RFR_PROTO_PROXIMITY;
            default:        next_kind = RFR_PROTO_PROPRIETARY;
        endcase
    end

    always_comb begin
        case (next_kind)
            RFR_PROTO_VICINITY:  next_preset = PRE_VIC;
            RFR_PROTO_PROXIMITY: next_preset = PRE_PROX;
            default:             next_preset = PRE_PROP;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            proto_mode <= 5'h02;
        end else if (proto_wr_i) begin
            proto_mode <= proto_mode_i;
        end
    end

    // only single-subcarrier vicinity and proximity type a detect collisions
    assign col_capable = (proto_mode[4:2] == 3'b000) || (proto_mode[4:2] == 3'b010);

    // receive wait register and preset
    always_ff @(posedge clock_i) begin
        if (sreset) begin
            rx_wait <= PRE_VIC;
        end else if (proto_wr_i) begin
            rx_wait <= next_preset;
        end else if (reg_wr_i && reg_addr_i == `RFR_ADDR_RX_WAIT) begin
            rx_wait <= reg_wdata_i;
        end
    end

    // receive blanking timer, restarted by every transmit end
    always_ff @(posedge clock_i) begin
        if (sreset) begin
            step_cnt   <= '0;
            steps_left <= '0;
        end else if (tx_end_i) begin
            step_cnt   <= '0;
            steps_left <= rx_wait;
        end else if (steps_left != 8'h00) begin
            if (step_cnt == 12'(STEP_CYC - 1)) begin
                step_cnt   <= '0;
                steps_left <= steps_left - 8'h01;
            end else begin
                step_cnt <= step_cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            rx_ignore_o <= 1'b0;
        end else if (tx_end_i) begin
            rx_ignore_o <= (rx_wait != 8'h00);
        end else if (steps_left == 8'h01 && step_cnt == 12'(STEP_CYC - 1)) begin
            rx_ignore_o <= 1'b0;
        end
    end

    // modulator and clock output control
    assign wr_hit_mod = reg_wr_i && reg_addr_i == `RFR_ADDR_MOD_CTRL;

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            mod_ctrl <= `RFR_RST_MOD_CTRL;
        end else if (proto_wr_i) begin
            // clock select survives a protocol change
            mod_ctrl <= (`RFR_RST_MOD_CTRL & 8'hcf) | {2'b00, mod_ctrl[5:4], 4'h0};
        end else if (wr_hit_mod) begin
            mod_ctrl <= {1'b0, reg_wdata_i[6:0]};
        end
    end

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            mod_ook_o        <= 1'b0;
            mod_depth_o      <= 3'h0;
            analog_test_en_o <= 1'b0;
        end else begin
            // pin override only meaningful in direct mode
            if (mod_ctrl[6] && direct_mode_i) begin
                mod_ook_o <= ask_ook_pin_i;
            end else begin
                mod_ook_o <= (mod_ctrl[2:0] == 3'b001);
            end
            mod_depth_o      <= mod_ctrl[2:0];
            analog_test_en_o <= mod_ctrl[3];
        end
    end

    // carrier divider: /2 and /4 of the 13.56 MHz carrier
    always_ff @(posedge clock_i) begin
        if (sreset) begin
            carrier_q <= 1'b0;
            div_cnt   <= 2'b00;
        end else begin
            carrier_q <= carrier_i;
            if (carrier_i && !carrier_q) begin
                div_cnt <= div_cnt + 2'b01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            system_clock_output_o <= 1'b0;
        end else begin
            case (mod_ctrl[5:4])
                2'b01:   system_clock_output_o <= div_cnt[1];
                2'b10:   system_clock_output_o <= div_cnt[0];
                2'b11:   system_clock_output_o <= carrier_q;
                default: system_clock_output_o <= 1'b0;
            endcase
        end
    end

    // receive filter, gain and regulator
    always_ff @(posedge clock_i) begin
        if (sreset || proto_wr_i) begin
            filt_gain <= `RFR_RST_FILT_GAIN;
        end else if (reg_wr_i && reg_addr_i == `RFR_ADDR_FILT_GAIN) begin
            filt_gain <= {reg_wdata_i[7:2], 2'b00};
        end
    end

    assign filter_sel_o = filt_gain[7:4];
    assign gain_cut_o   = filt_gain[3:2];

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            regulator <= `RFR_RST_REGULATOR;
        end else if (reg_wr_i && reg_addr_i == `RFR_ADDR_REGULATOR) begin
            regulator <= {reg_wdata_i[7:5], 2'b00, reg_wdata_i[2:0]};
        end
    end

    assign regulator_ctrl_o = regulator;

    // interrupt causes; a new event beats the read-phase clear
    always_ff @(posedge clock_i) begin
        if (sreset) begin
            fifo_cond_q <= 1'b0;
        end else begin
            fifo_cond_q <= fifo_cond;
        end
    end

    assign fifo_cond = (fifo_level_i < 4'(`RFR_FIFO_LOW_LIMIT)) ||
                       (fifo_level_i > 4'(`RFR_FIFO_HIGH_LIMIT));
    assign err_events = {fifo_cond && !fifo_cond_q, crc_err_i, parity_err_i,
                         framing_err_i, collision_i, noresp_i};

    always_ff @(posedge clock_i) begin
        if (sreset || proto_wr_i) begin
            cause <= 8'h00;
        end else begin
            // recorded regardless of the mask
            cause <= (read_phase_end_i ? 8'h00 : cause) |
                     {tx_start_i, rx_sof_i, err_events};
        end
    end

    always_ff @(posedge clock_i) begin
        if (sreset || proto_wr_i) begin
            irq_req <= 1'b0;
        end else if (tx_end_i || rx_end_i || |(err_events & irq_mask)) begin
            irq_req <= 1'b1;
        end else if (read_phase_end_i) begin
            irq_req <= 1'b0;
        end
    end

    assign irq_o = irq_req;

    // mask and collision position
    always_ff @(posedge clock_i) begin
        if (sreset) begin
            irq_mask <= `RFR_RST_MASK;
        end else if (reg_wr_i && reg_addr_i == `RFR_ADDR_COL_MASK) begin
            irq_mask <= reg_wdata_i[5:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            col_pos <= 10'h000;
        end else if (col_capable && collision_i) begin
            col_pos <= bit_pos_i;
        end else if (!col_capable && (crc_err_i || parity_err_i || framing_err_i)) begin
            col_pos <= bit_pos_i;
        end else if (reg_rd_i && (reg_addr_i == `RFR_ADDR_COL_MASK ||
                                  reg_addr_i == `RFR_ADDR_COL_LOW)) begin
            col_pos <= 10'h000;
        end
    end

    // signal strength held through the reply
    always_ff @(posedge clock_i) begin
        if (sreset || tx_start_i) begin
            strength <= 7'h00;
        end else if (rx_sof_i) begin
            strength <= {1'b0, aux_strength_i, active_strength_i};
        end
    end

    // fifo state is live; an empty fifo reads zero count
    always_comb begin
        fifo_state[7]   = 1'b0;
        fifo_state[6]   = (fifo_level_i == 4'(`RFR_FIFO_RX_MARK));
        fifo_state[5]   = (fifo_level_i == 4'(`RFR_FIFO_TX_MARK));
        fifo_state[4]   = fifo_overflow_i;
        fifo_state[3:0] = (fifo_level_i == 4'h0) ? 4'h0 : fifo_level_i - 4'h1;
    end

    // transmit length; a host write in the end cycle is kept
    always_ff @(posedge clock_i) begin
        if (sreset) begin
            tx_upper <= 8'h00;
            tx_lower <= 8'h00;
        end else begin
            if (reg_wr_i && reg_addr_i == `RFR_ADDR_TX_UPPER) begin
                tx_upper <= reg_wdata_i;
            end else if (tx_end_i) begin
                tx_upper <= 8'h00;
            end
            if (reg_wr_i && reg_addr_i == `RFR_ADDR_TX_LOWER) begin
                tx_lower <= reg_wdata_i;
            end else if (tx_end_i) begin
                tx_lower <= 8'h00;
            end
        end
    end

    assign tx_byte_count_o  = {tx_upper, tx_lower[7:4]};
    assign last_byte_bits_o = tx_lower[0] ? {1'b0, tx_lower[3:1]} : 4'h8;

    // read data, one cycle after the strobe; unmapped reads zero
    always_comb begin
        case (reg_addr_i)
            `RFR_ADDR_RX_WAIT:    rdata = rx_wait;
            `RFR_ADDR_MOD_CTRL:   rdata = mod_ctrl;
            `RFR_ADDR_FILT_GAIN:  rdata = filt_gain;
            `RFR_ADDR_REGULATOR:  rdata = regulator;
            `RFR_ADDR_CAUSE:      rdata = cause;
            `RFR_ADDR_COL_MASK:   rdata = {col_pos[9:8], irq_mask};
            `RFR_ADDR_COL_LOW:    rdata = col_pos[7:0];
            `RFR_ADDR_STRENGTH:   rdata = {1'b0, osc_stable_i, strength[5:0]};
            `RFR_ADDR_FIFO_STATE: rdata = fifo_state;
            `RFR_ADDR_TX_UPPER:   rdata = tx_upper;
            `RFR_ADDR_TX_LOWER:   rdata = tx_lower;
            default:              rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sreset) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata;
        end
    end

    a_wait_blank_start: assert property (@(posedge clock_i) disable iff (sreset)
        tx_end_i && rx_wait != 8'h00 |=> rx_ignore_o)
        else $error("receive blanking did not start");
    a_wait_blank_end: assert property (@(posedge clock_i) disable iff (sreset)
        rx_ignore_o && steps_left == 8'h01 && step_cnt == 12'(STEP_CYC - 1) && !tx_end_i
        |=> !rx_ignore_o)
        else $error("receive blanking overran");
    a_prox_preset: assert property (@(posedge clock_i) disable iff (sreset)
        proto_wr_i && proto_mode_i[4:2] == 3'b010 |=> rx_wait == 8'h07)
        else $error("proximity wait preset wrong");
    a_mod_proto_reset: assert property (@(posedge clock_i) disable iff (sreset)
        proto_wr_i |=> mod_ctrl[3:0] == 4'h1 && mod_ctrl[7:6] == 2'b00 &&
        mod_ctrl[5:4] == $past(mod_ctrl[5:4]))
        else $error("modulator reset on protocol write wrong");
    a_clk_out_off: assert property (@(posedge clock_i) disable iff (sreset)
        mod_ctrl[5:4] == 2'b00 |=> !system_clock_output_o)
        else $error("clock output active while disabled");
    a_ook_select: assert property (@(posedge clock_i) disable iff (sreset)
        !(mod_ctrl[6] && direct_mode_i) |=> mod_ook_o == ($past(mod_ctrl[2:0]) == 3'b001))
        else $error("keying choice wrong");
    a_irq_cause: assert property (@(posedge clock_i) disable iff (sreset)
        $rose(irq_o) |-> $past(tx_end_i || rx_end_i || |(err_events & irq_mask)))
        else $error("request raised without enabled cause");
    a_cause_clear: assert property (@(posedge clock_i) disable iff (sreset)
        read_phase_end_i && !tx_start_i && !rx_sof_i && err_events == 6'h00
        |=> cause == 8'h00)
        else $error("cause register not cleared after read");
    a_col_clear: assert property (@(posedge clock_i) disable iff (sreset)
        reg_rd_i && reg_addr_i == `RFR_ADDR_COL_LOW && !collision_i && !crc_err_i &&
        !parity_err_i && !framing_err_i |=> col_pos == 10'h000)
        else $error("collision position not cleared on read");
    a_strength_hold: assert property (@(posedge clock_i) disable iff (sreset)
        !rx_sof_i && !tx_start_i |=> $stable(strength))
        else $error("strength changed during reply");
    a_len_clear: assert property (@(posedge clock_i) disable iff (sreset)
        tx_end_i && !reg_wr_i |=> tx_byte_count_o == 12'h000)
        else $error("transmit length not cleared at end");
endmodule // rfr_cfg_status_regs

// File: core/rfr_params.svh
// register offsets, fifo limits, reset values and timing counts of the reader front end
// assumes a 250 MHz core clock; included by rfr_cfg_status_regs
`ifndef RFR_PARAMS_SVH
`define RFR_PARAMS_SVH

`define RFR_ADDR_RX_WAIT     5'h08
`define RFR_ADDR_MOD_CTRL    5'h09
`define RFR_ADDR_FILT_GAIN   5'h0a
`define RFR_ADDR_REGULATOR   5'h0b
`define RFR_ADDR_CAUSE       5'h0c
`define RFR_ADDR_COL_MASK    5'h0d
`define RFR_ADDR_COL_LOW     5'h0e
`define RFR_ADDR_STRENGTH    5'h0f
`define RFR_ADDR_FIFO_STATE  5'h1c
`define RFR_ADDR_TX_UPPER    5'h1d
`define RFR_ADDR_TX_LOWER    5'h1e

`define RFR_RST_MOD_CTRL     8'h11
`define RFR_RST_FILT_GAIN    8'h40
`define RFR_RST_REGULATOR    8'h87
`define RFR_RST_MASK         6'h3e

`define RFR_CLK_PERIOD_NS    4
// wait step 9.44 us, kept in hundredths of a microsecond
`define RFR_RXW_STEP_US_X100 944
`define RFR_RXW_STEP_CYCLES  ((`RFR_RXW_STEP_US_X100 * 10) / `RFR_CLK_PERIOD_NS)
`define RFR_PRESET_VIC_US    293
`define RFR_PRESET_PROX_US   66
`define RFR_PRESET_PROP_US   180
`define RFR_STEPS(us)        (((us) * 100 + `RFR_RXW_STEP_US_X100 / 2) / `RFR_RXW_STEP_US_X100)

`define RFR_FIFO_LOW_LIMIT   4
`define RFR_FIFO_HIGH_LIMIT  8
`define RFR_FIFO_RX_MARK     9
`define RFR_FIFO_TX_MARK     3

`endif

// File: core/rfr_pkg.sv
// types shared by the reader configuration and status registers
// assumes rfr_params.svh sits on the include path
package rfr_pkg;
    typedef enum logic [1:0] {
        RFR_PROTO_VICINITY,
        RFR_PROTO_PROXIMITY,
        RFR_PROTO_PROPRIETARY
    } rfr_proto_e;

    typedef logic [7:0] rfr_byte_t;
    typedef logic [4:0] rfr_addr_t;
endpackage

// File: verification/rfr_host_model.sv
// host side of the register port: turns address words into strobes
// assumes the bench calls access(); inputs change on falling clock edges
`timescale 1ns/1ns

module rfr_host_model (
    // clock
    input  wire logic               clock_i,
    // register port
    input  wire rfr_pkg::rfr_byte_t reg_rdata_i,
    output rfr_pkg::rfr_addr_t      reg_addr_o,
    output logic                    reg_wr_o,
    output logic                    reg_rd_o,
    output rfr_pkg::rfr_byte_t      reg_wdata_o,
    output logic                    read_phase_end_o
);
    import rfr_pkg::*;

    initial begin
        reg_addr_o       = 5'h00;
        reg_wr_o         = 1'b0;
        reg_rd_o         = 1'b0;
        reg_wdata_o      = 8'h00;
        read_phase_end_o = 1'b0;
    end

    // bit7 low marks an address, bit6 read; continuous mode not modelled
    task automatic access(input rfr_byte_t word, input rfr_byte_t wdata, output rfr_byte_t rdata);
        @(negedge clock_i);
        reg_addr_o  <= word[4:0];
        reg_rd_o    <= ~word[7] & word[6];
        reg_wr_o    <= ~word[7] & ~word[6];
        reg_wdata_o <= wdata;
        @(negedge clock_i);
        reg_rd_o         <= 1'b0;
        reg_wr_o         <= 1'b0;
        // released data shows the inverse, not a stale copy
        reg_wdata_o      <= ~wdata;
        read_phase_end_o <= word[6];
        rdata = reg_rdata_i;
        @(negedge clock_i);
        read_phase_end_o <= 1'b0;
    endtask
endmodule // rfr_host_model

// File: verification/rfr_cfg_status_regs_tb_top.sv
// self-checking bench for the configuration and status registers
// assumes rfr_host_model drives the register port
`timescale 1ns/1ns

module rfr_cfg_status_regs_tb_top;
    import rfr_pkg::*;

    logic clock_i = 1'b0, rst_i = 1'b1, enable_i = 1'b1, direct_mode_i = 1'b0;
    logic carrier_i = 1'b0, ask_ook_pin_i = 1'b0, fifo_overflow_i = 1'b0, osc_stable_i = 1'b0;
    logic [9:0] evv = 10'h000, bit_pos_i = 10'h000;
    logic [4:0] proto_mode_i = 5'h02;
    logic [3:0] fifo_level_i = 4'h5;
    logic [2:0] active_strength_i = 3'h0, aux_strength_i = 3'h0;
    wire logic proto_wr_i, tx_start_i, tx_end_i, rx_sof_i, rx_end_i;
    wire logic crc_err_i, parity_err_i, framing_err_i, collision_i, noresp_i;
    rfr_addr_t reg_addr_i;
    rfr_byte_t reg_wdata_i, reg_rdata_o, got;
    logic reg_wr_i, reg_rd_i, read_phase_end_i, mod_ook_o, rx_ignore_o, irq_o;
    logic system_clock_output_o, analog_test_en_o;
    logic [2:0] mod_depth_o;
    logic [3:0] filter_sel_o, last_byte_bits_o;
    logic [1:0] gain_cut_o;
    logic [7:0] regulator_ctrl_o;
    logic [11:0] tx_byte_count_o;
    int miscompares = 0, n_compared = 0, i;
    rfr_addr_t raddr[10] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c,
                             5'h0d, 5'h0e, 5'h1d, 5'h1e, 5'h10};
    rfr_byte_t rrst[10] = '{8'h1f, 8'h11, 8'h40, 8'h87, 8'h00,
                            8'h3e, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0] pmode[3] = '{5'h08, 5'h13, 5'h02};
    rfr_byte_t pwait[3] = '{8'h07, 8'h13, 8'h1f};

    assign {proto_wr_i, tx_start_i, tx_end_i, rx_sof_i, rx_end_i} = evv[9:5];
    assign {crc_err_i, parity_err_i, framing_err_i, collision_i, noresp_i} = evv[4:0];

    always #2 clock_i = ~clock_i;
    // slow stand-in for the carrier, only to keep the divider moving
    // edges fall on falling clock edges, never on the sampling edge
    always #36 carrier_i = ~carrier_i;

    rfr_cfg_status_regs dut (
        .clock_i, .rst_i, .enable_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
        .read_phase_end_i, .reg_rdata_o, .proto_wr_i, .proto_mode_i, .direct_mode_i,
        .tx_start_i, .tx_end_i, .rx_sof_i, .rx_end_i, .crc_err_i, .parity_err_i,
        .framing_err_i, .collision_i, .noresp_i, .bit_pos_i, .fifo_level_i,
        .fifo_overflow_i, .active_strength_i, .aux_strength_i, .osc_stable_i, .carrier_i,
        .ask_ook_pin_i, .system_clock_output_o, .mod_ook_o, .mod_depth_o,
        .analog_test_en_o, .rx_ignore_o, .filter_sel_o, .gain_cut_o, .regulator_ctrl_o,
        .tx_byte_count_o, .last_byte_bits_o, .irq_o
    );

    rfr_host_model host (
        .clock_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .read_phase_end_o(read_phase_end_i)
    );

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input rfr_addr_t a, input rfr_byte_t d);
        host.access({3'b000, a}, d, got);
    endtask

    task automatic rd(input rfr_addr_t a, input rfr_byte_t exp);
        host.access({3'b010, a}, 8'h00, got);
        chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, got});
    endtask

    // one-cycle event pulse
    task automatic ev(input logic [9:0] v);
        @(negedge clock_i);
        evv = v;
        @(negedge clock_i);
        evv = 10'h000;
    endtask

    // divided clock output flips once every n carrier rises
    task automatic clk_div(input rfr_byte_t m, input int n);
        logic v;
        wr(5'h09, m);
        @(posedge carrier_i);
        repeat (3) @(negedge clock_i);
        v = system_clock_output_o;
        repeat (n) @(posedge carrier_i);
        repeat (3) @(negedge clock_i);
        chk("clock divider", {11'h0, ~v}, {11'h0, system_clock_output_o});
    endtask

    task automatic give_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clock_i);
        rst_i = 1'b0;
        foreach (raddr[j]) rd(raddr[j], rrst[j]);
        wr(5'h09, 8'h35);
        wr(5'h0a, 8'h9c);
        wr(5'h0b, 8'h05);
        chk("depth", 12'h5, {9'h0, mod_depth_o});
        chk("keying", 12'h0, {11'h0, mod_ook_o});
        chk("filter", 12'h9, {8'h0, filter_sel_o});
        chk("gain", 12'h3, {10'h0, gain_cut_o});
        chk("analog", 12'h0, {11'h0, analog_test_en_o});
        @(negedge carrier_i);
        repeat (3) @(negedge clock_i);
        chk("clock out", 12'h0, {11'h0, system_clock_output_o});
        @(posedge carrier_i);
        repeat (3) @(negedge clock_i);
        chk("clock out", 12'h1, {11'h0, system_clock_output_o});
        foreach (pmode[j]) begin
            proto_mode_i = pmode[j];
            ev(10'h200);
            rd(5'h08, pwait[j]);
        end
        rd(5'h09, 8'h31);
        rd(5'h0a, 8'h40);
        rd(5'h0b, 8'h05);
        chk("keying", 12'h1, {11'h0, mod_ook_o});
        chk("regulator", 12'h05, {4'h0, regulator_ctrl_o});
        wr(5'h08, 8'h01);
        ev(10'h100);
        chk("irq", 12'h0, {11'h0, irq_o});
        ev(10'h080);
        chk("irq", 12'h1, {11'h0, irq_o});
        for (i = 0; rx_ignore_o === 1'b1 && i < 3000; i++) @(negedge clock_i);
        chk("blanking", 12'd2360, i[11:0]);
        rd(5'h0c, 8'h80);
        chk("irq", 12'h0, {11'h0, irq_o});
        active_strength_i = 3'h5;
        aux_strength_i = 3'h3;
        osc_stable_i = 1'b1;
        ev(10'h040);
        chk("irq", 12'h0, {11'h0, irq_o});
        ev(10'h020);
        chk("irq", 12'h1, {11'h0, irq_o});
        rd(5'h0c, 8'h40);
        rd(5'h0f, 8'h5d);
        ev(10'h100);
        rd(5'h0f, 8'h40);
        bit_pos_i = 10'h2a5;
        for (i = 0; i < 5; i++) begin
            ev({5'h00, 5'h01 << i});
            chk("irq", {11'h0, i != 0}, {11'h0, irq_o});
            rd(5'h0c, 8'h01 << i);
        end
        rd(5'h0d, 8'hbe);
        rd(5'h0e, 8'h00);
        proto_mode_i = 5'h13;
        ev(10'h200);
        bit_pos_i = 10'h155;
        ev(10'h008);
        rd(5'h0e, 8'h55);
        fifo_level_i = 4'h9;
        rd(5'h0c, 8'h20);
        rd(5'h1c, 8'h48);
        // leave the high region first: the flag marks entry into a region
        fifo_level_i = 4'h5;
        @(negedge clock_i);
        fifo_level_i = 4'h3;
        fifo_overflow_i = 1'b1;
        rd(5'h0c, 8'h20);
        rd(5'h1c, 8'h32);
        wr(5'h1d, 8'hab);
        wr(5'h1e, 8'hc7);
        chk("count", 12'habc, tx_byte_count_o);
        chk("last bits", 12'h3, {8'h0, last_byte_bits_o});
        wr(5'h1e, 8'hc6);
        chk("last bits", 12'h8, {8'h0, last_byte_bits_o});
        ev(10'h080);
        rd(5'h1d, 8'h00);
        rd(5'h1e, 8'h00);
        direct_mode_i = 1'b1;
        ask_ook_pin_i = 1'b1;
        wr(5'h09, 8'h40);
        chk("keying", 12'h1, {11'h0, mod_ook_o});
        direct_mode_i = 1'b0;
        @(negedge clock_i);
        chk("keying", 12'h0, {11'h0, mod_ook_o});
        clk_div(8'h20, 1);
        clk_div(8'h18, 2);
        chk("analog", 12'h1, {11'h0, analog_test_en_o});
        wr(5'h09, 8'h08);
        chk("clock out", 12'h0, {11'h0, system_clock_output_o});
        enable_i = 1'b0;
        @(negedge clock_i);
        enable_i = 1'b1;
        rd(5'h09, 8'h11);
        rd(5'h0a, 8'h40);
        rd(5'h0b, 8'h87);
        give_verdict();
    end

    // whole run is a few thousand cycles
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule // rfr_cfg_status_regs_tb_top
